// ===== rtl/acr_cal_regs.v
// calibration and configuration register bank for channels 1 and 2
// assumes an avalon-mm master on clock; word address = register index
// Overview of operation
// - channel 1 offset low byte kept in bits 15:8 of its low offset register
// - channel 2 offset bits 23:8 kept in all of its high offset register
// - gain word is unsigned 24 bits, 0.0 to under 2.0, bits 23:8 high
// - gain low byte kept in bits 15:8 of each low gain register
// - bits 7:0 of every low calibration register read zero, not writable
// - channel 1 high gain at 0x11, resets to 0x8000 for unity gain
// - channel 2 config bits 15:6 are a 10-bit phase delay
// - phase delay field is signed two's complement
// - channel 2 config bits 5:3 read zero and are not writable
// - config bit 2 clear uses global dc block, set bypasses it
// - config bits 1:0 choose normal, shorted, positive or negative test input
// - channel 2 config at 0x13, resets to zero
// - channel 2 high gain at 0x16 reset 0x8000, low gain 0x17 reset zero
// - channel 2 high offset at 0x14, low offset at 0x15, both reset zero
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "acr_consts.vh"

module acr_cal_regs (
  input wire clock,
  input wire sys_rst,
  input wire [`ACR_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [`ACR_DATA_W-1:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [`ACR_DATA_W-1:0] avs_readdata,
  output wire avs_waitrequest,
  input wire global_dc_block_setting,
  output wire [23:0] chan1_offset_cal,
  output wire [23:0] chan1_gain_cal,
  output wire [23:0] chan2_offset_cal,
  output wire [23:0] chan2_gain_cal,
  output wire signed [9:0] chan2_phase_delay,
  output wire chan2_dc_block_off,
  output wire chan2_dc_block_en,
  output wire [1:0] chan2_input_select,
  output wire chan2_sel_normal,
  output wire chan2_sel_short,
  output wire chan2_sel_pos_test,
  output wire chan2_sel_neg_test
);

  // one wait cycle: request seen, answer registered, then waitrequest drops
  reg ack_ff;
  reg [`ACR_DATA_W-1:0] rdata_ff;
  reg [7:0] chan1_offset_low_byte_ff;
  reg [15:0] chan1_gain_high_word_ff;
  reg [7:0] chan1_gain_low_byte_ff;
  reg [9:0] chan2_phase_ff;
  reg chan2_dcblk_ff;
  reg [1:0] chan2_mux_ff;
  reg [15:0] chan2_offset_high_word_ff;
  reg [7:0] chan2_offset_low_byte_ff;
  reg [15:0] chan2_gain_high_word_ff;
  reg [7:0] chan2_gain_low_byte_ff;

  // channel 1 offset high word sits outside this bank
  reg [15:0] rd_word;
  reg [15:0] wr_word;
  wire req = avs_read | avs_write;
  wire do_write = avs_write & ack_ff;

  // merge write data with current content per byte lane
  function [15:0] lane_merge;
    input [15:0] cur;
    input [15:0] wd;
    input [1:0] be;
    begin
      lane_merge = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
    end
  endfunction

  // readback view of each register; reserved bits are forced to zero
  always @* begin
    rd_word = `ACR_RST_ZERO16;
    case (avs_address)
      `ACR_IDX_CH1_OCAL_LO: rd_word = {chan1_offset_low_byte_ff, 8'h00};
      `ACR_IDX_CH1_GCAL_HI: rd_word = chan1_gain_high_word_ff;
      `ACR_IDX_CH1_GCAL_LO: rd_word = {chan1_gain_low_byte_ff, 8'h00};
      `ACR_IDX_CH2_CONFIG: rd_word = {chan2_phase_ff, 3'h0, chan2_dcblk_ff, chan2_mux_ff};
      `ACR_IDX_CH2_OCAL_HI: rd_word = chan2_offset_high_word_ff;
      `ACR_IDX_CH2_OCAL_LO: rd_word = {chan2_offset_low_byte_ff, 8'h00};
      `ACR_IDX_CH2_GCAL_HI: rd_word = chan2_gain_high_word_ff;
      `ACR_IDX_CH2_GCAL_LO: rd_word = {chan2_gain_low_byte_ff, 8'h00};
      default: rd_word = `ACR_RST_ZERO16;
    endcase
  end

  always @* begin
    wr_word = lane_merge(rd_word, avs_writedata[15:0], avs_byteenable[1:0]);
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= `ACR_RDATA_UNMAPPED;
    end else begin
      // ack pulses for one cycle so back-to-back requests each wait once
      ack_ff <= req & ~ack_ff;
      if (avs_read & ~ack_ff) begin
        rdata_ff <= {16'h0000, rd_word};
      end
    end
  end

  // writes commit on the edge where waitrequest is low
  always @(posedge clock) begin
    if (sys_rst) begin
      chan1_offset_low_byte_ff <= 8'h00;
      chan1_gain_high_word_ff <= `ACR_RST_GCAL_HI;
      chan1_gain_low_byte_ff <= 8'h00;
      chan2_phase_ff <= 10'h000;
      chan2_dcblk_ff <= 1'b0;
      chan2_mux_ff <= `ACR_MUX_NORMAL;
      chan2_offset_high_word_ff <= `ACR_RST_ZERO16;
      chan2_offset_low_byte_ff <= 8'h00;
      chan2_gain_high_word_ff <= `ACR_RST_GCAL_HI;
      chan2_gain_low_byte_ff <= 8'h00;
    end else if (do_write) begin
      // only defined field bits are stored, reserved bits drop away
      case (avs_address)
        `ACR_IDX_CH1_OCAL_LO:
          chan1_offset_low_byte_ff <= wr_word[`ACR_LO_BYTE_MSB:`ACR_LO_BYTE_LSB];
        `ACR_IDX_CH1_GCAL_HI:
          chan1_gain_high_word_ff <= wr_word;
        `ACR_IDX_CH1_GCAL_LO:
          chan1_gain_low_byte_ff <= wr_word[`ACR_LO_BYTE_MSB:`ACR_LO_BYTE_LSB];
        `ACR_IDX_CH2_CONFIG: begin
          chan2_phase_ff <= wr_word[`ACR_PHASE_MSB:`ACR_PHASE_LSB];
          chan2_dcblk_ff <= wr_word[`ACR_DCBLK_BIT];
          chan2_mux_ff <= wr_word[`ACR_MUX_MSB:`ACR_MUX_LSB];
        end
        `ACR_IDX_CH2_OCAL_HI:
          chan2_offset_high_word_ff <= wr_word;
        `ACR_IDX_CH2_OCAL_LO:
          chan2_offset_low_byte_ff <= wr_word[`ACR_LO_BYTE_MSB:`ACR_LO_BYTE_LSB];
        `ACR_IDX_CH2_GCAL_HI:
          chan2_gain_high_word_ff <= wr_word;
        `ACR_IDX_CH2_GCAL_LO:
          chan2_gain_low_byte_ff <= wr_word[`ACR_LO_BYTE_MSB:`ACR_LO_BYTE_LSB];
        default: ;
      endcase
    end
  end

  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // channel 1 offset bits 23:8 live elsewhere; they read as zero here
  assign chan1_offset_cal = {16'h0000, chan1_offset_low_byte_ff};
  assign chan1_gain_cal = {chan1_gain_high_word_ff, chan1_gain_low_byte_ff};
  assign chan2_offset_cal = {chan2_offset_high_word_ff, chan2_offset_low_byte_ff};
  assign chan2_gain_cal = {chan2_gain_high_word_ff, chan2_gain_low_byte_ff};
  assign chan2_phase_delay = chan2_phase_ff;
  assign chan2_dc_block_off = chan2_dcblk_ff;
  assign chan2_dc_block_en = global_dc_block_setting & ~chan2_dcblk_ff;
  assign chan2_input_select = chan2_mux_ff;
  assign chan2_sel_normal = (chan2_mux_ff == `ACR_MUX_NORMAL);
  assign chan2_sel_short = (chan2_mux_ff == `ACR_MUX_SHORT);
  assign chan2_sel_pos_test = (chan2_mux_ff == `ACR_MUX_POS_TEST);
  assign chan2_sel_neg_test = (chan2_mux_ff == `ACR_MUX_NEG_TEST);

endmodule

// ===== rtl/acr_consts.vh
// register offsets, field positions and reset values of the calibration bank
// assumes word addressing on the register bus, one 16-bit register per word
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH

`define ACR_ADDR_W 8
`define ACR_DATA_W 32
`define ACR_REG_W 16

// register indices; byte address is four times the index
`define ACR_IDX_CH1_OCAL_LO 8'h10
`define ACR_IDX_CH1_GCAL_HI 8'h11
`define ACR_IDX_CH1_GCAL_LO 8'h12
`define ACR_IDX_CH2_CONFIG 8'h13
`define ACR_IDX_CH2_OCAL_HI 8'h14
`define ACR_IDX_CH2_OCAL_LO 8'h15
`define ACR_IDX_CH2_GCAL_HI 8'h16
`define ACR_IDX_CH2_GCAL_LO 8'h17

`define ACR_RST_GCAL_HI 16'h8000
`define ACR_RST_ZERO16 16'h0000

// low calibration registers: stored byte in bits 15:8, bits 7:0 read zero
`define ACR_LO_BYTE_MSB 15
`define ACR_LO_BYTE_LSB 8

// channel configuration fields
`define ACR_PHASE_MSB 15
`define ACR_PHASE_LSB 6
`define ACR_DCBLK_BIT 2
`define ACR_MUX_MSB 1
`define ACR_MUX_LSB 0

// input selection codes
`define ACR_MUX_NORMAL 2'h0
`define ACR_MUX_SHORT 2'h1
`define ACR_MUX_POS_TEST 2'h2
`define ACR_MUX_NEG_TEST 2'h3

`define ACR_RDATA_UNMAPPED 32'h0000_0000

`endif

// ===== tb/acr_cal_regs_monitor.sv
// assertions on the calibration bank ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module acr_cal_regs_monitor (
  input wire clock,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire global_dc_block_setting,
  input wire [23:0] chan1_offset_cal,
  input wire [23:0] chan1_gain_cal,
  input wire [23:0] chan2_gain_cal,
  input wire signed [9:0] chan2_phase_delay,
  input wire chan2_dc_block_off,
  input wire chan2_dc_block_en,
  input wire [1:0] chan2_input_select,
  input wire chan2_sel_normal,
  input wire chan2_sel_short,
  input wire chan2_sel_pos_test,
  input wire chan2_sel_neg_test
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  req_one_wait_a: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
    else $error("request not answered after one wait cycle");
  wait_needs_req_a: assert property (avs_waitrequest |-> (avs_read || avs_write))
    else $error("waitrequest without a request");
  rd_upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  rd_data_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  dc_enable_a: assert property (chan2_dc_block_en == (global_dc_block_setting && !chan2_dc_block_off))
    else $error("dc block enable wrong");
  sel_decode_a: assert property (
    {chan2_sel_neg_test, chan2_sel_pos_test, chan2_sel_short, chan2_sel_normal}
    == (4'h1 << chan2_input_select)) else $error("input select decode wrong");
  ofs1_upper_a: assert property (chan1_offset_cal[23:8] == 16'h0000)
    else $error("channel 1 offset upper bits not zero");
  gain_reset_a: assert property ($fell(sys_rst) |->
    chan1_gain_cal == 24'h80_0000 && chan2_gain_cal == 24'h80_0000)
    else $error("gain not unity after reset");
  fields_hold_a: assert property (!(avs_write && !avs_waitrequest) |=> $stable({chan1_gain_cal, chan2_gain_cal, chan2_phase_delay}))
    else $error("field changed without a write");
endmodule

// ===== tb/tb.sv
// directed testbench for the calibration register bank
// assumes acr_cal_regs answers every request after one wait cycle
`timescale 1ns/100ps
module tb;
  logic clock = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, gdc = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic [15:0] q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, sn, ss, sp, sg, dc_off, dc_en;
  wire [23:0] o1, g1, o2, g2;
  wire signed [9:0] ph;
  wire [1:0] sel;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  logic [15:0] msk [8] = '{16'hff00, 16'hffff, 16'hff00, 16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00};
  acr_cal_regs i_dut (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .global_dc_block_setting(gdc), .chan1_offset_cal(o1),
    .chan1_gain_cal(g1), .chan2_offset_cal(o2), .chan2_gain_cal(g2), .chan2_phase_delay(ph),
    .chan2_dc_block_off(dc_off), .chan2_dc_block_en(dc_en), .chan2_input_select(sel),
    .chan2_sel_normal(sn), .chan2_sel_short(ss), .chan2_sel_pos_test(sp), .chan2_sel_neg_test(sg));
  always #50 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge, released at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= !w;
    avs_write <= w;
    do begin @(posedge clock); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk(1, 0);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      bus(0, 8'(8'h10 + i), 16'h0000);
      chk(q, (i == 1 || i == 6) ? 16'h8000 : 16'h0000);
    end
    chk(g1, 24'h80_0000);
    chk(g2, 24'h80_0000);
    chk(o2, 24'h00_0000);
    chk({sn, dc_en, dc_off, ph}, 13'h1000);
  endtask
  task automatic t_rw;
    for (int i = 0; i < 8; i++) bus(1, 8'(8'h10 + i), 16'hffff);
    @(negedge clock);
    chk({o1, g1}, {24'h00_00ff, 24'hff_ffff});
    chk({o2, g2}, {24'hff_ffff, 24'hff_ffff});
    for (int i = 0; i < 8; i++) begin
      bus(0, 8'(8'h10 + i), 16'h0000);
      chk(q, msk[i]);
      bus(1, 8'(8'h10 + i), 16'h0000);
      bus(0, 8'(8'h10 + i), 16'h0000);
      chk(q, 16'h0000);
    end
    be <= 4'h1;
    bus(1, 8'h14, 16'h1234);
    be <= 4'hf;
    bus(0, 8'h14, 16'h0000);
    chk(q, 16'h0034);
    bus(1, 8'h18, 16'hffff);
    bus(0, 8'h18, 16'h0000);
    chk(q, 16'h0000);
  endtask
  task automatic t_cfg;
    for (int m = 0; m < 4; m++) begin
      gdc <= m[1];
      bus(1, 8'h13, {10'h200, 3'b111, m[0], m[1:0]});
      @(negedge clock);
      chk({ph, sel, dc_en, dc_off, sg, sp, ss, sn},
        {10'h200, m[1:0], m[1] & !m[0], m[0], 4'h1 << m});
      chk(ph < 0, 1);
      bus(0, 8'h13, 16'h0000);
      chk(q, {10'h200, 3'b000, m[0], m[1:0]});
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset;
    t_rw;
    t_cfg;
    stop_test;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_errors++;
      stop_test;
    end
  end
endmodule
bind acr_cal_regs acr_cal_regs_monitor i_mon (.*);
